// >>> pkg/spmtc_cfg.svh
// Offsets, field positions, reset values and rate counts of the serial port.
// Assumes a 12-bit APB byte address with every register in one aligned word.
`ifndef SPMTC_CFG_SVH
`define SPMTC_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define SPMTC_RXCTL_ADDR   12'h018
`define SPMTC_TXCTL_ADDR   12'h098
`define SPMTC_RATE_ADDR    12'h09C
`define SPMTC_DIR_ADDR     12'h0A0
`define SPMTC_TXDATA_ADDR  12'h0A4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPMTC_CLK_SRC_BIT   7
`define SPMTC_NINE_BIT      6
`define SPMTC_TX_ON_BIT     5
`define SPMTC_SYNC_BIT      4
`define SPMTC_HIGH_RATE_BIT 2
`define SPMTC_EMPTY_BIT     1
`define SPMTC_NINTH_BIT     0
`define SPMTC_PORT_ON_BIT   7
`define SPMTC_HOLD_FULL_BIT 8

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define SPMTC_TXCTL_RST   8'h00
`define SPMTC_TXCTL_WMASK 8'hF5
`define SPMTC_RXCTL_RST   8'h00
`define SPMTC_RXCTL_WMASK 8'h80
`define SPMTC_RATE_RST    8'h00
`define SPMTC_DIR_RST     8'hFF

// ----------------------------------------------------------------------------
// Generator ticks per bit
// ----------------------------------------------------------------------------
`define SPMTC_TICKS_ASYNC_LO 7'h40
`define SPMTC_TICKS_ASYNC_HI 7'h10
`define SPMTC_TICKS_SYNC     7'h04

`endif

// >>> pkg/spmtc_pkg.sv
// Types shared by the serial port mode and transmit control files.
// Assumes the configuration header is included wherever numbers are needed.
package spmtc_pkg;

  // --------------------------------------------------------------------------
  // Operating modes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPMTC_MODE_ASYNC,
    SPMTC_MODE_SYNC_MASTER,
    SPMTC_MODE_SYNC_SLAVE
  } spmtc_mode_type;

endpackage : spmtc_pkg

// >>> src/spmtc_baud_gen.sv
// Free-running rate timer: one enable pulse per period of (period + 1) clocks.
// Assumes the period input comes from a register on the same clock.
module spmtc_baud_gen #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] period_in,
  output logic                  tick_out
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic             wrap;

  // ----------------------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------------------
  // A new period takes hold at the next wrap, so a write never gives a runt
  assign wrap      = (count_r == '0);
  assign count_nxt = wrap ? period_in : count_r - 1'b1;
  assign tick_out  = wrap;

  // Count state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule : spmtc_baud_gen

// >>> src/spmtc_top.sv
// Serial port mode selection and transmitter with its APB register file.
// Assumes an APB master on clk_in and pin buffers resolved outside.
`include "spmtc_cfg.svh"

module spmtc_top
  import spmtc_pkg::*;
#(
  parameter int RATE_WIDTH = 8
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        tx_ck_in,
  output logic             tx_ck_out,
  output logic             tx_ck_oe_out,
  output logic             rx_dt_out,
  output logic             rx_dt_oe_out
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [7:0]            txctl_r;
  logic [7:0]            rxctl_r;
  logic [RATE_WIDTH-1:0] rate_r;
  logic [7:0]            dir_r;
  logic [7:0]            hold_r;
  logic                  hold_full_r;
  logic                  hold_full_nxt;
  logic [10:0]           shift_r;
  logic [10:0]           shift_nxt;
  logic [3:0]            bits_r;
  logic [3:0]            bits_nxt;
  logic [6:0]            pre_r;
  logic [6:0]            pre_nxt;
  logic [31:0]           prdata_r;
  logic                  ck_s1_r;
  logic                  ck_s2_r;
  logic                  ck_s3_r;
  logic                  ck_stable_r;
  logic                  ck_out_r;
  logic                  ck_oe_r;
  logic                  dt_out_r;
  logic                  dt_oe_r;
  logic                  access;
  logic                  setup;
  logic                  wr;
  logic                  sel_txctl;
  logic                  sel_rxctl;
  logic                  sel_rate;
  logic                  sel_dir;
  logic                  sel_txdata;
  logic                  mapped;
  logic [31:0]           read_mux;
  logic                  sync_mode;
  logic                  port_on;
  logic                  pins_on;
  logic                  tx_on;
  logic                  nine;
  logic                  empty;
  logic                  busy;
  logic                  load;
  logic                  tick;
  logic [6:0]            ticks_per_bit;
  logic                  pre_last;
  logic                  ck_fall;
  logic                  bit_adv;
  spmtc_mode_type        mode;

  // Word match on the aligned address, low two bits ignored
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
    addr_hit = (a[11:2] == r[11:2]);
  endfunction : addr_hit

  // ----------------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------------
  // Zero wait states; unmapped words answer with an error and no effect
  assign setup       = psel_in & ~penable_in;
  assign access      = psel_in & penable_in;
  assign wr          = access & pwrite_in & pstrb_in[0] & mapped;
  assign sel_txctl   = addr_hit(paddr_in, `SPMTC_TXCTL_ADDR);
  assign sel_rxctl   = addr_hit(paddr_in, `SPMTC_RXCTL_ADDR);
  assign sel_rate    = addr_hit(paddr_in, `SPMTC_RATE_ADDR);
  assign sel_dir     = addr_hit(paddr_in, `SPMTC_DIR_ADDR);
  assign sel_txdata  = addr_hit(paddr_in, `SPMTC_TXDATA_ADDR);
  assign mapped      = sel_txctl | sel_rxctl | sel_rate | sel_dir | sel_txdata;
  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~mapped;
  assign prdata_out  = prdata_r;

  // Read view; unused and reserved bits read as zero
  // control word layout
  assign read_mux =
      sel_txctl  ? {24'h000000, txctl_r[7:2], empty, txctl_r[0]} :
      sel_rxctl  ? {24'h000000, rxctl_r} :
      sel_rate   ? {{(32-RATE_WIDTH){1'b0}}, rate_r} :
      sel_dir    ? {24'h000000, dir_r} :
      sel_txdata ? {23'h000000, hold_full_r, hold_r} : 32'h00000000;

  // ----------------------------------------------------------------------------
  // Mode and pin ownership
  // ----------------------------------------------------------------------------
  // mode selection
  assign sync_mode = txctl_r[`SPMTC_SYNC_BIT];
  assign mode      = !sync_mode ? SPMTC_MODE_ASYNC :
                     txctl_r[`SPMTC_CLK_SRC_BIT] ? SPMTC_MODE_SYNC_MASTER :
                     SPMTC_MODE_SYNC_SLAVE;
  assign port_on   = rxctl_r[`SPMTC_PORT_ON_BIT];
  assign pins_on   = port_on & (dir_r[7:6] == 2'b11);
  assign tx_on     = txctl_r[`SPMTC_TX_ON_BIT] & pins_on;
  assign nine      = txctl_r[`SPMTC_NINE_BIT];
  assign empty     = (bits_r == 4'h0);
  assign busy      = ~empty;
  assign load      = tx_on & empty & hold_full_r;

  // ----------------------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------------------
  // shared rate timer
  spmtc_baud_gen #(
    .WIDTH      (RATE_WIDTH)
  ) u_rate (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .period_in  (rate_r),
    .tick_out   (tick)
  );

  assign ticks_per_bit = sync_mode ? `SPMTC_TICKS_SYNC :
                         txctl_r[`SPMTC_HIGH_RATE_BIT] ? `SPMTC_TICKS_ASYNC_HI :
                         `SPMTC_TICKS_ASYNC_LO;
  assign pre_last      = (pre_r == ticks_per_bit - 7'h01);
  // Slave shifts on a falling edge seen after the filter agrees
  assign ck_fall       = ck_stable_r & (ck_s2_r == ck_s3_r) & ~ck_s3_r;
  assign bit_adv       = busy & ((mode == SPMTC_MODE_SYNC_SLAVE) ? ck_fall : (tick & pre_last));
  assign pre_nxt       = (!busy || mode == SPMTC_MODE_SYNC_SLAVE) ? 7'h00 :
                         !tick ? pre_r :
                         pre_last ? 7'h00 : pre_r + 7'h01;

  // ----------------------------------------------------------------------------
  // Holding register and shifter
  // ----------------------------------------------------------------------------
  // Data written while the holding word is full is dropped
  assign hold_full_nxt = load ? 1'b0 :
                         (wr & sel_txdata & ~hold_full_r) ? 1'b1 : hold_full_r;

  // Async frame: start, data LSB first, optional ninth, stop; sync has no framing
  // stop when disabled
  assign shift_nxt = load ? (sync_mode ? {2'b11, txctl_r[`SPMTC_NINTH_BIT], hold_r} :
                             nine ? {1'b1, txctl_r[`SPMTC_NINTH_BIT], hold_r, 1'b0} :
                                    {2'b11, hold_r, 1'b0}) :
                     bit_adv ? {1'b1, shift_r[10:1]} : shift_r;
  assign bits_nxt  = !tx_on ? 4'h0 :
                     load ? (sync_mode ? (nine ? 4'h9 : 4'h8) : (nine ? 4'hB : 4'hA)) :
                     bit_adv ? bits_r - 4'h1 : bits_r;

  // Register writes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      txctl_r <= `SPMTC_TXCTL_RST;
      rxctl_r <= `SPMTC_RXCTL_RST;
      rate_r  <= RATE_WIDTH'(`SPMTC_RATE_RST);
      dir_r   <= `SPMTC_DIR_RST;
      hold_r  <= 8'h00;
    end else if (wr) begin
      if (sel_txctl) txctl_r <= pwdata_in[7:0] & `SPMTC_TXCTL_WMASK;
      if (sel_rxctl) rxctl_r <= pwdata_in[7:0] & `SPMTC_RXCTL_WMASK;
      if (sel_rate)  rate_r  <= pwdata_in[RATE_WIDTH-1:0];
      if (sel_dir)   dir_r   <= pwdata_in[7:0];
      if (sel_txdata && !hold_full_r) hold_r <= pwdata_in[7:0];
    end
  end

  // Transmit state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hold_full_r <= 1'b0;
      shift_r     <= 11'h7FF;
      bits_r      <= 4'h0;
      pre_r       <= 7'h00;
    end else begin
      hold_full_r <= hold_full_nxt;
      shift_r     <= shift_nxt;
      bits_r      <= bits_nxt;
      pre_r       <= pre_nxt;
    end
  end

  // Read data captured in setup, stable through the access phase
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata_r <= 32'h00000000;
    end else if (setup) begin
      prdata_r <= read_mux;
    end
  end

  // External clock filter: three stages, change taken when two agree
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ck_s1_r     <= 1'b0;
      ck_s2_r     <= 1'b0;
      ck_s3_r     <= 1'b0;
      ck_stable_r <= 1'b0;
    end else begin
      ck_s1_r <= tx_ck_in;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      if (ck_s2_r == ck_s3_r) ck_stable_r <= ck_s3_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------------
  // Registered to keep the pins glitch free; one clock of lag on each pin
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ck_out_r <= 1'b1;
      ck_oe_r  <= 1'b0;
      dt_out_r <= 1'b0;
      dt_oe_r  <= 1'b0;
    end else begin
      case (mode)
        SPMTC_MODE_ASYNC: begin
          ck_out_r <= shift_r[0] | empty;
          ck_oe_r  <= pins_on;
          dt_out_r <= 1'b0;
          dt_oe_r  <= 1'b0;
        end
        SPMTC_MODE_SYNC_MASTER: begin
          ck_out_r <= busy & pre_r[1];
          ck_oe_r  <= pins_on;
          dt_out_r <= shift_r[0];
          dt_oe_r  <= pins_on & busy;
        end
        SPMTC_MODE_SYNC_SLAVE: begin
          ck_out_r <= 1'b0;
          ck_oe_r  <= 1'b0;
          dt_out_r <= shift_r[0];
          dt_oe_r  <= pins_on & busy;
        end
        default: begin
          ck_out_r <= 1'b1;
          ck_oe_r  <= 1'b0;
          dt_out_r <= 1'b0;
          dt_oe_r  <= 1'b0;
        end
      endcase
    end
  end

  assign tx_ck_out    = ck_out_r;
  assign tx_ck_oe_out = ck_oe_r;
  assign rx_dt_out    = dt_out_r;
  assign rx_dt_oe_out = dt_oe_r;

endmodule : spmtc_top

// >>> bench/spmtc_checker.sv
// Bus and pin relations of the serial port top, seen at its ports only.
// Assumes the bind below and one clock with a synchronous reset.
module spmtc_checker #(
  parameter int RATE_WIDTH = 8
) (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        tx_ck_in,
  input wire logic        tx_ck_out,
  input wire logic        tx_ck_oe_out,
  input wire logic        rx_dt_out,
  input wire logic        rx_dt_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Access phase and address decode
  wire acc = psel_in & penable_in;
  wire hit = paddr_in[11:2] inside {10'h006, 10'h026, 10'h027, 10'h028, 10'h029};
  wire lose = acc & pwrite_in & pstrb_in[0] & (paddr_in == 12'h0A0) & ~&pwdata_in[7:6];

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // Read setup cycle at one word index
  sequence rd_setup(w);
    psel_in && !penable_in && !pwrite_in && paddr_in[11:2] == w;
  endsequence

  ready_always_a: assert property (pready_out)
    else $error("ready low");
  unmapped_err_a: assert property (acc && !hit |-> pslverr_out)
    else $error("no error on unmapped access");
  mapped_ok_a: assert property (acc && hit |-> !pslverr_out)
    else $error("error on mapped access");
  err_idle_a: assert property (!acc |-> !pslverr_out)
    else $error("error outside access");
  txctl_rsvd_a: assert property (rd_setup(10'h026) |=> !prdata_out[3] && !prdata_out[31:8])
    else $error("reserved control bits set");
  rxctl_rsvd_a: assert property (rd_setup(10'h006) |=> prdata_out[6:0] == 7'h00)
    else $error("reserved port bits set");
  rdata_hold_a: assert property ($changed(prdata_out) |->
    $past(psel_in) && !$past(penable_in) || $past(sys_rst_in))
    else $error("read data moved outside setup");
  port_loss_a: assert property (lose |-> ##2 !tx_ck_oe_out && !rx_dt_oe_out)
    else $error("pins still driven");
  reset_idle_a: assert property (disable iff (1'b0)
    sys_rst_in |=> tx_ck_out && !tx_ck_oe_out && !rx_dt_oe_out)
    else $error("pins not idle after reset");
endmodule : spmtc_checker

bind spmtc_top spmtc_checker #(.RATE_WIDTH(RATE_WIDTH)) chk_u (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .tx_ck_in(tx_ck_in), .tx_ck_out(tx_ck_out), .tx_ck_oe_out(tx_ck_oe_out),
  .rx_dt_out(rx_dt_out), .rx_dt_oe_out(rx_dt_oe_out));

// >>> bench/spmtc_peer.sv
// Far side serial device that clocks a slave-mode port and keeps its bits.
// Assumes the port presents its first data bit before the first clock.
module spmtc_peer (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic       dt_in,
  output logic            ck_out,
  output logic [7:0]      got_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_r;
  logic [4:0] left_r;
  initial begin
    ck_out = 1'b0;
    got_out = 8'h00;
    ph_r = 3'h0;
    left_r = 5'h00;
  end
  // external clock: eight pulses, idle low, data taken on the rise
  always @(posedge clk_in) begin
    if (go_in) begin
      left_r <= 5'h10;
    end else if (left_r != 5'h00) begin
      ph_r <= ph_r + 3'h1;
      if (ph_r == 3'h7) begin
        ck_out <= ~ck_out;
        left_r <= left_r - 5'h01;
        if (!ck_out) got_out <= {dt_in, got_out[7:1]};
      end
    end
  end
endmodule : spmtc_peer

// >>> bench/tb_serial_port_mode_and_tx_control.sv
// Bench: async and master frames predicted from a bit queue and compared at every bit.
// Assumes the checker binds itself and the peer clocks the slave mode.
module tb_serial_port_mode_and_tx_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, sys_rst_in, psel, pen, pwr, go, serr, ready, ck, ck_oe, dt, dt_oe, pck;
  logic [11:0] addr;
  logic [31:0] wd, rd, prd;
  logic [7:0] got;
  logic [31:0] seed = 32'd87434;
  int err_total = 0, total_checks = 0, cyc = 0;

  // Clock pin level resolved from the port and the peer
  wire tx_ck_pin = ck_oe ? ck : pck;
  // Data pin as the peer sees it; a released pin shows the inverse
  wire rx_dt_pin = dt_oe ? dt : ~dt;

  spmtc_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wd), .pstrb_in(4'hF),
    .prdata_out(prd), .pready_out(ready), .pslverr_out(serr), .tx_ck_in(tx_ck_pin),
    .tx_ck_out(ck), .tx_ck_oe_out(ck_oe), .rx_dt_out(dt), .rx_dt_oe_out(dt_oe));
  spmtc_peer peer_u (.clk_in(clk_in), .go_in(go), .dt_in(rx_dt_pin), .ck_out(pck),
    .got_out(got));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // Hang guard well above the expected run
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : waitc
  // One APB transfer; the release waits one edge so no signal moves twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    @(posedge clk_in);
    while (ready !== 1'b1) @(posedge clk_in);
    rd = prd;
    rd[31] = rd[31] | serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
  endtask : apb
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    logic [31:0] r;
    logic [7:0] c;
    logic q[$];
    int p, h, bt, m, k;
    time t0;
    {sys_rst_in, psel, pen, pwr, go, addr, wd} = {1'b1, 48'h0};
    waitc(5);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    apb(0, 12'h098, 0); chk(rd, 32'h02);
    apb(0, 12'h018, 0); chk(rd, 32'h00);
    apb(0, 12'h0A0, 0); chk(rd, 32'hFF);
    apb(0, 12'h09C, 0); chk(rd, 32'h00);
    apb(0, 12'h0F0, 0); chk(rd, 32'h80000000);
    apb(1, 12'h098, 32'hFF);
    apb(0, 12'h098, 0); chk(rd, 32'hF7);
    chk(ck_oe, 0);
    apb(1, 12'h018, 32'h80);
    waitc(2); chk(ck_oe, 1);
    apb(1, 12'h0A0, 32'h40);
    waitc(2); chk(ck_oe, 0);
    apb(1, 12'h0A0, 32'hFF);
    $display("test pins done");
    // Modes: async low, async high, master low, master high, slave
    for (m = 0; m < 5; m++) begin
      r = rnd();
      p = r[8];
      h = m % 2;
      bt = (p + 1) * (m > 1 ? 4 : (h ? 16 : 64));
      c = {m == 2 || m == 3, m < 4 && r[9], 1'b1, m > 1, 1'b0, h[0], 1'b0, r[10]};
      q = {};
      if (m < 2) q.push_back(0);
      for (k = 0; k < 8; k++) q.push_back(r[k]);
      if (c[6]) q.push_back(r[10]);
      if (m < 2) q.push_back(1);
      apb(1, 12'h09C, p);
      apb(1, 12'h098, c);
      apb(1, 12'h0A4, r[7:0]);
      if (m < 2) begin
        while (ck !== 1'b0) @(posedge clk_in);
        waitc(bt / 2);
      end
      chk(ck_oe, m < 4);
      if (m == 4) begin
        apb(0, 12'h098, 0); chk(rd, c);
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        waitc(20); chk(dt_oe, 1);
        waitc(130); chk(got, r[7:0]);
      end else begin
        foreach (q[k]) begin
          if (m < 2) begin
            chk(ck, q[k]);
            waitc(bt);
          end else begin
            while (ck !== 1'b0) @(posedge clk_in);
            while (ck !== 1'b1) @(posedge clk_in);
            if (k == 0) t0 = $time;
            chk({dt_oe, dt}, {1'b1, q[k]});
          end
        end
        if (m > 1) chk(($time - t0) / 4, (q.size() - 1) * bt);
      end
      waitc(bt + 4);
      apb(0, 12'h098, 0); chk(rd, c | 8'h02);
      $display("test mode %0d done", m);
    end
    finish_test();
  end
endmodule : tb_serial_port_mode_and_tx_control
